// File: rcc_capture.sv
`default_nettype none
module rcc_capture #(
    parameter int DEPTH = rcc_pkg::BUF_DEPTH,
    parameter logic [rcc_pkg::SYNC_W-1:0] WB_SYNC = rcc_pkg::WB_SYNC_DEF,
    parameter logic [rcc_pkg::SYNC_W-1:0] NB_SYNC = rcc_pkg::NB_SYNC_DEF
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic data_pin,
    input wire logic [rcc_pkg::ADDR_W-1:0] addr,
    input wire logic [rcc_pkg::DATA_W-1:0] wr_data,
    input wire logic wr_stb,
    input wire logic rd_stb,
    output logic [rcc_pkg::DATA_W-1:0] rd_data,
    output logic [1:0] analyzer_input_source,
    output logic capture_active,
    output logic buffer_full
);
    localparam int IW = rcc_pkg::IDX_W;

    rcc_pkg::rcc_ctrl_t ctrl_q;
    rcc_pkg::rcc_state_t st_q, st_d;
    logic [rcc_pkg::RATE_W-1:0] rate_q, phase_q;
    logic [rcc_pkg::GATE_W-1:0] gate_q, gate_left_q;
    logic [rcc_pkg::PAT_W-1:0] pat_q, mask_q;
    logic [rcc_pkg::PLEN_W-1:0] plen_q;
    logic [rcc_pkg::DIDX_W-1:0] didx_q;
    logic [DEPTH-1:0] buf_q;
    logic [IW-1:0] wr_idx_q;
    logic [rcc_pkg::SYNC_W-1:0] sync_q;
    logic [rcc_pkg::SUPV_W-1:0] supv_sh_q, supv_disp_q;
    logic [rcc_pkg::DATA_W-1:0] rd_data_q, rd_data_d, data_word;
    logic pad_q, done_q, ok_q, ovf_q, std_q, prev_q, data_s;

    // Match against pattern; bit i of the pattern is the i-th bit after trigger
    function automatic logic pat_match(input logic [DEPTH-1:0] b,
                                       input logic [IW-1:0] fill,
                                       input logic off,
                                       input logic [rcc_pkg::PAT_W-1:0] pat,
                                       input logic [rcc_pkg::PAT_W-1:0] mask,
                                       input logic [rcc_pkg::PLEN_W-1:0] len);
        logic bad;
        logic [IW-1:0] k;
        bad = 1'b0;
        k = '0;
        for (int i = 0; i < rcc_pkg::PAT_W; i++) begin
            k = IW'(i) + IW'(off);
            if (i < int'(len) && mask[i] && (k >= fill || b[k] != pat[i])) begin
                bad = 1'b1;
            end
        end
        return !bad;
    endfunction

    // Standard supervisory code lookup
    function automatic logic is_std(input logic [rcc_pkg::SUPV_W-1:0] code);
        logic hit;
        hit = 1'b0;
        for (int i = 0; i < rcc_pkg::SUPV_N; i++) begin
            if (code == rcc_pkg::SUPV_CODES[i]) begin
                hit = 1'b1;
            end
        end
        return hit;
    endfunction

    rcc_pin_sync u_pin (
        .clk(clk),
        .rst(rst),
        .ce(ce),
        .pin(data_pin),
        .level(data_s)
    );

    // Bus decode
    wire wr_ctrl = wr_stb && addr == rcc_pkg::A_CTRL;
    wire wr_cmd = wr_stb && addr == rcc_pkg::A_CMD;
    wire arm = wr_cmd && wr_data[rcc_pkg::CMD_ARM];
    wire stop = wr_cmd && wr_data[rcc_pkg::CMD_STOP];

    // Bit sampler: realign on each pin edge, sample mid bit
    wire edge_s = data_s != prev_q;
    wire [rcc_pkg::RATE_W-1:0] half = rate_q >> 1;
    wire rx_bit = ce && rate_q >= rcc_pkg::RATE_MIN && !edge_s && phase_q == half;
    wire bit_v = data_s ^ ctrl_q.inv;

    // Mode decode
    // channel and measure
    wire nb_mode = ctrl_q.nb && ctrl_q.voice;
    wire nb_data = nb_mode && ctrl_q.meas == rcc_pkg::M_DATA;
    wire supv_en = nb_mode && ctrl_q.meas == rcc_pkg::M_SUPV && st_q != rcc_pkg::ST_IDLE;
    wire cap_ok = !nb_mode || nb_data;
    wire pad_start = !ctrl_q.voice;
    wire [rcc_pkg::SYNC_W-1:0] sync_d = {sync_q[rcc_pkg::SYNC_W-2:0], bit_v};
    wire [rcc_pkg::SUPV_W-1:0] supv_d = {supv_sh_q[rcc_pkg::SUPV_W-2:0], bit_v};
    wire sync_hit = rx_bit && sync_d == (nb_mode ? NB_SYNC : WB_SYNC);

    // Capture sequencing terms
    // trigger on last sync bit
    wire start = st_q == rcc_pkg::ST_HUNT && !stop && !arm && sync_hit && cap_ok;
    wire full_now = wr_idx_q == IW'(DEPTH);
    wire gate_end = gate_left_q == '0;
    wire nb_end = wr_idx_q == rcc_pkg::NB_LEN;
    wire cap_end = st_q == rcc_pkg::ST_CAPT && (nb_mode ? nb_end : (gate_end || full_now));
    wire end_ev = cap_end && !stop && !arm;
    wire wr_bit = st_q == rcc_pkg::ST_CAPT && rx_bit && !cap_end;
    wire pat_ok = pat_match(buf_q, wr_idx_q, pad_q, pat_q, mask_q, plen_q);
    // count excludes the pad bit, unused in narrowband
    wire [IW-1:0] bit_count = nb_mode ? '0 : wr_idx_q - IW'(pad_q);
    wire [rcc_pkg::DATA_W-1:0] stat_w = {24'h000000, st_q, std_q, full_now, ovf_q,
                                         ok_q, done_q};

    // 32-bit word of captured bits, first bit in the top, unfilled bits zero
    genvar j;
    generate
        for (j = 0; j < rcc_pkg::DATA_W; j++) begin : g_word
            wire [IW-1:0] idx = {didx_q, {rcc_pkg::WSH_W{1'b0}}} + IW'(j);
            assign data_word[rcc_pkg::DATA_W-1-j] = ok_q && idx < wr_idx_q && buf_q[idx];
        end
    endgenerate

    // Capture state machine
    always_comb begin
        st_d = st_q;
        if (stop) begin
            st_d = rcc_pkg::ST_IDLE;
        end else if (arm) begin
            st_d = rcc_pkg::ST_HUNT;
        end else begin
            case (st_q)
                rcc_pkg::ST_IDLE: st_d = rcc_pkg::ST_IDLE;
                rcc_pkg::ST_HUNT: begin
                    if (start) begin
                        st_d = rcc_pkg::ST_CAPT;
                    end
                end
                rcc_pkg::ST_CAPT: begin
                    // rearm in continuous or narrowband message
                    if (cap_end) begin
                        st_d = (nb_mode || ctrl_q.cont) ? rcc_pkg::ST_HUNT : rcc_pkg::ST_IDLE;
                    end
                end
                default: st_d = rcc_pkg::ST_IDLE;
            endcase
        end
    end

    // Read mux
    always_comb begin
        rd_data_d = '0;
        if (addr == rcc_pkg::A_CTRL) begin
            rd_data_d = rcc_pkg::DATA_W'(ctrl_q);
        end else if (addr == rcc_pkg::A_RATE) begin
            rd_data_d = rcc_pkg::DATA_W'(rate_q);
        end else if (addr == rcc_pkg::A_GATE) begin
            rd_data_d = gate_q;
        end else if (addr == rcc_pkg::A_PAT) begin
            rd_data_d = pat_q;
        end else if (addr == rcc_pkg::A_MASK) begin
            rd_data_d = mask_q;
        end else if (addr == rcc_pkg::A_PLEN) begin
            rd_data_d = rcc_pkg::DATA_W'(plen_q);
        end else if (addr == rcc_pkg::A_STAT) begin
            rd_data_d = stat_w;
        end else if (addr == rcc_pkg::A_COUNT) begin
            rd_data_d = rcc_pkg::DATA_W'(bit_count);
        end else if (addr == rcc_pkg::A_DIDX) begin
            rd_data_d = rcc_pkg::DATA_W'(didx_q);
        end else if (addr == rcc_pkg::A_DATA) begin
            rd_data_d = data_word;
        end else if (addr == rcc_pkg::A_SUPV) begin
            rd_data_d = rcc_pkg::DATA_W'(supv_disp_q);
        end
    end

    // Configuration registers
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ctrl_q <= rcc_pkg::CTRL_RST;
            rate_q <= rcc_pkg::RATE_RST;
            gate_q <= rcc_pkg::GATE_RST;
            pat_q <= rcc_pkg::PAT_RST;
            mask_q <= rcc_pkg::PAT_RST;
            plen_q <= rcc_pkg::PLEN_RST;
            didx_q <= '0;
        end else if (ce && wr_stb) begin
            if (wr_ctrl) begin
                ctrl_q <= rcc_pkg::rcc_ctrl_t'(wr_data[rcc_pkg::CTRL_W-1:0]);
            end else if (addr == rcc_pkg::A_RATE) begin
                rate_q <= wr_data[rcc_pkg::RATE_W-1:0];
            end else if (addr == rcc_pkg::A_GATE) begin
                gate_q <= wr_data;
            end else if (addr == rcc_pkg::A_PAT) begin
                pat_q <= wr_data;
            end else if (addr == rcc_pkg::A_MASK) begin
                mask_q <= wr_data;
            end else if (addr == rcc_pkg::A_PLEN) begin
                plen_q <= wr_data[rcc_pkg::PLEN_W-1:0];
            end else if (addr == rcc_pkg::A_DIDX) begin
                didx_q <= wr_data[rcc_pkg::DIDX_W-1:0];
            end
        end
    end

    // Read data, one cycle after the strobe
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rd_data_q <= '0;
        end else if (ce) begin
            rd_data_q <= rd_stb ? rd_data_d : '0;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            phase_q <= '0;
            prev_q <= 1'b0;
            sync_q <= '0;
        end else if (ce) begin
            prev_q <= data_s;
            phase_q <= (edge_s || phase_q >= rate_q - rcc_pkg::RATE_ONE) ? '0 : phase_q + 1'b1;
            if (rx_bit) begin
                sync_q <= sync_d;
            end
        end
    end

    // State, write index and gate timer
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_q <= rcc_pkg::ST_IDLE;
            wr_idx_q <= '0;
            gate_left_q <= '0;
            pad_q <= 1'b0;
        end else if (ce) begin
            st_q <= st_d;
            if (start) begin
                // pad bit ahead of control data
                wr_idx_q <= IW'(pad_start);
                pad_q <= pad_start;
                gate_left_q <= gate_q;
            end else begin
                if (wr_bit) begin
                    wr_idx_q <= wr_idx_q + 1'b1;
                end
                if (st_q == rcc_pkg::ST_CAPT && !gate_end) begin
                    gate_left_q <= gate_left_q - 1'b1;
                end
            end
        end
    end

    // Bit storage
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            buf_q <= '0;
        end else if (ce) begin
            if (start && pad_start) begin
                buf_q[0] <= 1'b0;
            end else if (wr_bit) begin
                buf_q[wr_idx_q] <= bit_v;
            end
        end
    end

    // Result flags; an arm clears them even in the cycle a capture ends
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            done_q <= 1'b0;
            ok_q <= 1'b0;
            ovf_q <= 1'b0;
        end else if (ce) begin
            if (end_ev) begin
                done_q <= 1'b1;
                ok_q <= nb_mode || pat_ok;
                // buffer filled before the gate ran out
                ovf_q <= !nb_mode && full_now && !gate_end;
            end else if (arm || start) begin
                done_q <= 1'b0;
                ok_q <= 1'b0;
                ovf_q <= arm ? 1'b0 : ovf_q;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            supv_sh_q <= '0;
            supv_disp_q <= '0;
            std_q <= 1'b0;
        end else if (ce) begin
            if (arm) begin
                std_q <= 1'b0;
                supv_disp_q <= '0;
            end else if (supv_en && rx_bit) begin
                supv_sh_q <= supv_d;
                if (is_std(supv_d)) begin
                    supv_disp_q <= supv_d;
                    std_q <= 1'b1;
                end else if (!std_q) begin
                    supv_disp_q <= supv_d;
                end
            end
        end
    end

    assign rd_data = rd_data_q;
    assign analyzer_input_source = ctrl_q.src;
    assign capture_active = st_q == rcc_pkg::ST_CAPT;
    assign buffer_full = full_now;

    // Checks
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    chk_arm_hunt: assert property (
        ce && arm && !stop |=> st_q == rcc_pkg::ST_HUNT) else $error("arm did not hunt");
    chk_sync_start: assert property (
        st_q == rcc_pkg::ST_CAPT && $past(st_q) == rcc_pkg::ST_HUNT |-> $past(sync_hit))
        else $error("capture began without sync");
    chk_gate_stop: assert property (
        ce && st_q == rcc_pkg::ST_CAPT && !nb_mode && gate_end && !stop && !arm
        |=> st_q != rcc_pkg::ST_CAPT) else $error("capture ran past gate");
    chk_idx_bound: assert property (
        wr_idx_q <= IW'(DEPTH)) else $error("write index beyond buffer");
    chk_full_nowrite: assert property (
        buffer_full |-> !wr_bit) else $error("write while full");
    chk_ovf_flag: assert property (
        ce && end_ev && !nb_mode && full_now && !gate_end |=> ovf_q && done_q)
        else $error("overflow not flagged");
    chk_bit_polarity: assert property (
        ce && wr_bit |=> buf_q[$past(wr_idx_q)] == ($past(data_s) ^ $past(ctrl_q.inv)))
        else $error("bit polarity wrong");
    chk_pad_zero: assert property (
        ce && start && !ctrl_q.voice |=> !buf_q[0] && wr_idx_q == IW'(1))
        else $error("control pad bit missing");
    chk_match_gate: assert property (
        data_word != '0 |-> ok_q) else $error("data shown without match");
    chk_nb_count: assert property (
        nb_mode |-> bit_count == '0) else $error("narrowband count shown");
    chk_single_idle: assert property (
        ce && end_ev && !nb_mode && !ctrl_q.cont |=> st_q == rcc_pkg::ST_IDLE)
        else $error("single capture did not stop");
    chk_stop_idle: assert property (
        ce && stop |=> st_q == rcc_pkg::ST_IDLE) else $error("stop ignored");
    chk_nb_retrig: assert property (
        ce && end_ev && nb_mode |-> wr_idx_q == rcc_pkg::NB_LEN ##1 st_q == rcc_pkg::ST_HUNT)
        else $error("narrowband message wrong");

    cov_capture: cover property (st_q == rcc_pkg::ST_HUNT ##1 st_q == rcc_pkg::ST_CAPT);
    cov_overflow: cover property (ce && end_ev && full_now && !gate_end);
    cov_nb_msg: cover property (ce && end_ev && nb_mode);
    cov_std_code: cover property (!std_q ##1 std_q);
endmodule
`default_nettype wire

// File: rcc_capture_tb.sv
`default_nettype none
module rcc_capture_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int P = 16;
    logic clk, rst, ce, wr_stb, rd_stb, pin, full, act;
    logic [rcc_pkg::ADDR_W-1:0] addr;
    logic [31:0] wr_data, rd_data, rv, seed, e;
    logic [1:0] src;
    int n_errors, check_count;
    logic q[$];
    rcc_capture dut (.clk(clk), .rst(rst), .ce(ce), .data_pin(pin), .addr(addr),
        .wr_data(wr_data), .wr_stb(wr_stb), .rd_stb(rd_stb), .rd_data(rd_data),
        .analyzer_input_source(src), .capture_active(act), .buffer_full(full));
    rcc_radio_model #(.P(P)) radio (.clk(clk), .pin(pin));
    // Free running clock
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // Register bus master
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wr_data <= d;
        wr_stb <= 1'b1;
        @(posedge clk);
        wr_stb <= 1'b0;
    endtask
    task automatic chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x);
        @(posedge clk);
        addr <= a;
        rd_stb <= 1'b1;
        @(posedge clk);
        rd_stb <= 1'b0;
        #1 rv = rd_data & m;
        check_count++;
        if (rv !== x) begin
            n_errors++;
            $display("wrong value at %0t: reg %h got %h exp %h", $time, a, rv, x);
        end
    endtask
    task automatic chkf(input logic g, input logic x);
        check_count++;
        if (g !== x) begin
            n_errors++;
            $display("wrong value at %0t: flag got %b exp %b", $time, g, x);
        end
    endtask
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    // Expected packed word from the bit queue, pad bits read zero
    function automatic logic [31:0] expw(int pad, logic inv, int w, int len);
        logic [31:0] r;
        int k;
        r = '0;
        for (int i = 0; i < 32; i++) begin
            k = w * 32 + i - pad;
            if (k >= 0 && k < len) r[31-i] = q[k] ^ inv;
        end
        return r;
    endfunction
    task automatic gen(input int n);
        q.delete();
        repeat (n) begin
            seed = lfsr(seed);
            q.push_back(seed[0]);
        end
    endtask
    // Arm, then dotting, sync word and the queued bits
    task automatic run(input logic [31:0] c, input logic [10:0] s, input logic [31:0] g);
        wr(rcc_pkg::A_CTRL, c);
        wr(rcc_pkg::A_GATE, g);
        wr(rcc_pkg::A_CMD, 32'h1);
        radio.dot(8);
        // Line carries the sync in the radio's own polarity
        for (int i = 10; i >= 0; i--) radio.send(s[i] ^ c[1]);
        foreach (q[i]) radio.send(q[i]);
    endtask
    task automatic conclude();
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // Watchdog
    initial begin
        #400000;
        n_errors++;
        conclude();
    end
    // Main sequence
    initial begin
        {wr_stb, rd_stb, addr, wr_data} = '0;
        ce = 1'b1;
        n_errors = 0;
        check_count = 0;
        seed = 32'h6D78;
        rst = 1'b1;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        chk(rcc_pkg::A_RATE, 32'hFFFF, 32'h14);
        chk(rcc_pkg::A_GATE, 32'hFFFFFFFF, 32'hFFFF);
        chk(rcc_pkg::A_STAT, 32'hE0, 32'h20);
        chk(8'h3C, 32'hFFFFFFFF, 32'h0);
        // Clock enable low: a write must not land
        @(posedge clk);
        ce <= 1'b0;
        wr(rcc_pkg::A_DIDX, 32'h5);
        ce <= 1'b1;
        chk(rcc_pkg::A_DIDX, 32'h3F, 32'h0);
        wr(rcc_pkg::A_RATE, P);
        wr(rcc_pkg::A_DIDX, 32'h0);
        // Wideband voice, gate ends the capture
        gen(48);
        run(32'h41, rcc_pkg::WB_SYNC_DEF, 36 * P);
        chkf(src == 2'b01, 1'b1);
        chk(rcc_pkg::A_STAT, 32'hEF, 32'h23);
        chk(rcc_pkg::A_DATA, 32'hFFFFFFFF, expw(0, 0, 0, 48));
        chk(rcc_pkg::A_COUNT, 32'hFFFFFFFF, 32'h24);
        // Control channel, inverted polarity
        gen(48);
        run(32'h02, rcc_pkg::WB_SYNC_DEF, 36 * P);
        chk(rcc_pkg::A_DATA, 32'hFFFFFFFF, expw(1, 1, 0, 48));
        // Pattern filter, mismatch then a mismatch on a masked bit only
        for (int k = 0; k < 2; k++) begin
            gen(48);
            wr(rcc_pkg::A_PLEN, 32'h4);
            wr(rcc_pkg::A_MASK, 32'hD);
            wr(rcc_pkg::A_PAT, {28'h0, q[3], q[2], ~q[1], q[0] ^ (k == 0)});
            run(32'h00, rcc_pkg::WB_SYNC_DEF, 36 * P);
            e = k ? expw(1, 0, 0, 48) : 32'h0;
            chk(rcc_pkg::A_STAT, 32'h2, k << 1);
            chk(rcc_pkg::A_DATA, 32'hFFFFFFFF, e);
        end
        wr(rcc_pkg::A_PLEN, 32'h0);
        // Narrowband message, gate set tiny to show it is unused
        gen(48);
        run(32'h19, rcc_pkg::NB_SYNC_DEF, 32'h5);
        chk(rcc_pkg::A_STAT, 32'hE3, 32'h43);
        for (int w = 0; w < 2; w++) begin
            wr(rcc_pkg::A_DIDX, w);
            chk(rcc_pkg::A_DATA, 32'hFFFFFFFF, expw(0, 0, w, 48));
        end
        chk(rcc_pkg::A_COUNT, 32'hFFFFFFFF, 32'h0);
        wr(rcc_pkg::A_CMD, 32'h2);
        wr(rcc_pkg::A_DIDX, 32'h0);
        // Supervisory display, a standard code sent after dotting
        wr(rcc_pkg::A_CTRL, 32'h09);
        wr(rcc_pkg::A_CMD, 32'h1);
        radio.dot(8);
        for (int i = 23; i >= 0; i--) radio.send(rcc_pkg::SUPV_CODES[7][i]);
        chk(rcc_pkg::A_SUPV, 32'hFFFFFF, rcc_pkg::SUPV_CODES[7]);
        chk(rcc_pkg::A_STAT, 32'h10, 32'h10);
        wr(rcc_pkg::A_CMD, 32'h2);
        // Stop in mid capture
        gen(10);
        run(32'h01, rcc_pkg::WB_SYNC_DEF, 1000 * P);
        chkf(act, 1'b1);
        wr(rcc_pkg::A_CMD, 32'h2);
        @(posedge clk);
        #1 chkf(act, 1'b0);
        // Control buffer fills before the gate
        gen(1600);
        run(32'h00, rcc_pkg::WB_SYNC_DEF, 40000);
        chkf(full, 1'b1);
        chk(rcc_pkg::A_COUNT, 32'hFFFFFFFF, 32'h62F);
        chk(rcc_pkg::A_STAT, 32'hEC, 32'h2C);
        conclude();
    end
endmodule
`default_nettype wire

// File: rcc_pin_sync.sv
`default_nettype none
module rcc_pin_sync (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic pin,
    output logic level
);
    logic s1_q, s2_q, s3_q, level_q;

    // Three stages; level moves only once stages two and three agree
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
            level_q <= 1'b0;
        end else if (ce) begin
            s1_q <= pin;
            s2_q <= s1_q;
            s3_q <= s2_q;
            if (s2_q == s3_q) begin
                level_q <= s3_q;
            end
        end
    end

    assign level = level_q;
endmodule
`default_nettype wire

// File: rcc_pkg.sv
`default_nettype none
package rcc_pkg;
    // Bus and field widths
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int IDX_W = 11;
    localparam int RATE_W = 16;
    localparam int GATE_W = 32;
    localparam int PAT_W = 32;
    localparam int PLEN_W = 6;
    localparam int DIDX_W = 6;
    localparam int WSH_W = 5;
    localparam int CTRL_W = 8;
    localparam int SYNC_W = 11;
    localparam int SUPV_W = 24;
    localparam int SUPV_N = 14;

    // Register offsets
    localparam logic [ADDR_W-1:0] A_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] A_CMD = 8'h04;
    localparam logic [ADDR_W-1:0] A_RATE = 8'h08;
    localparam logic [ADDR_W-1:0] A_GATE = 8'h0C;
    localparam logic [ADDR_W-1:0] A_PAT = 8'h10;
    localparam logic [ADDR_W-1:0] A_MASK = 8'h14;
    localparam logic [ADDR_W-1:0] A_PLEN = 8'h18;
    localparam logic [ADDR_W-1:0] A_STAT = 8'h1C;
    localparam logic [ADDR_W-1:0] A_COUNT = 8'h20;
    localparam logic [ADDR_W-1:0] A_DIDX = 8'h24;
    localparam logic [ADDR_W-1:0] A_DATA = 8'h28;
    localparam logic [ADDR_W-1:0] A_SUPV = 8'h2C;

    // Command bits
    localparam int CMD_ARM = 0;
    localparam int CMD_STOP = 1;

    // Status bit positions
    localparam int STAT_DONE = 0;
    localparam int STAT_OK = 1;
    localparam int STAT_OVF = 2;
    localparam int STAT_FULL = 3;
    localparam int STAT_STD = 4;
    localparam int STAT_STATE = 5;

    // Buffer sizes: control keeps one zero pad bit ahead of its 1583 bits
    localparam int BUF_DEPTH = 1584;
    localparam int CAP_VOICE = 1584;
    localparam int CAP_CTRL = 1583;
    localparam logic [IDX_W-1:0] NB_MSG = 11'h024;
    localparam logic [IDX_W-1:0] NB_PAR = 11'h00C;
    localparam logic [IDX_W-1:0] NB_LEN = NB_MSG + NB_PAR;

    // Sync words and supervisory codes, plain defaults
    localparam logic [SYNC_W-1:0] WB_SYNC_DEF = 11'h712;
    localparam logic [SYNC_W-1:0] NB_SYNC_DEF = 11'h5A3;
    localparam logic [SUPV_W-1:0] SUPV_CODES [SUPV_N] = '{
        24'h000001, 24'h000002, 24'h000003, 24'h000004, 24'h000005,
        24'h000006, 24'h000007, 24'h000011, 24'h000012, 24'h000013,
        24'h000014, 24'h000015, 24'h000016, 24'h000017};

    // Reset values and sampler rate constants
    localparam logic [RATE_W-1:0] RATE_RST = 16'h0014;
    localparam logic [RATE_W-1:0] RATE_MIN = 16'h0002;
    localparam logic [RATE_W-1:0] RATE_ONE = 16'h0001;
    localparam logic [GATE_W-1:0] GATE_RST = 32'h0000FFFF;
    localparam logic [PAT_W-1:0] PAT_RST = 32'h00000000;
    localparam logic [PLEN_W-1:0] PLEN_RST = 6'h00;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_HUNT = 3'b010,
        ST_CAPT = 3'b100
    } rcc_state_t;

    typedef enum logic [1:0] {
        M_SUPV = 2'b00,
        M_DATA = 2'b01,
        M_DTMF = 2'b10
    } rcc_meas_t;

    typedef struct packed {
        logic [1:0] src;
        rcc_meas_t meas;
        logic nb;
        logic cont;
        logic inv;
        logic voice;
    } rcc_ctrl_t;

    localparam rcc_ctrl_t CTRL_RST = 8'h00;
endpackage
`default_nettype wire

// File: rcc_radio_model.sv
`default_nettype none
// Demodulated bit stream from the radio under test
module rcc_radio_model #(
    parameter int P = 16
) (
    input wire logic clk,
    output logic pin
);
    timeunit 1ns;
    timeprecision 1ps;
    initial pin = 1'b0;
    task automatic send(input logic b);
        pin <= b;
        repeat (P) @(posedge clk);
    endtask
    // Dotting between frames, so the line never sits still
    task automatic dot(input int n);
        for (int i = 0; i < n; i++) send(i[0]);
    endtask
endmodule
`default_nettype wire
